//--- xcvr_pkg.sv
/*
 * shared constants and carrier types for the backplane transceiver.
 * assumes all pins are sampled on one 10 MHz clock.
 */
package xcvr_pkg;

   // ------------------------------------------------------------
   // sizes and reset values
   // ------------------------------------------------------------
   localparam int BYTE_WIDTH = 8;
   localparam int BIT_LANES = 2;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic BIT_RESET = 1'h0;
   localparam logic OE_RESET = 1'h0; // pin released

   // ------------------------------------------------------------
   // pin carriers: data plus output enable (high while driving)
   // ------------------------------------------------------------
   typedef struct packed {
      logic oe;
      logic [BYTE_WIDTH-1:0] data;
   } byte_pin_type;

   typedef struct packed {
      logic [BIT_LANES-1:0] oe;
      logic [BIT_LANES-1:0] data;
   } lane_pin_type;

endpackage

//--- latch_path.sv
/*
 * one direction of the byte path: transparent, latched or clocked storage.
 * assumes the capture clock is an ordinary input synchronous to clock.
 */
`timescale 1ns/10ps

module latch_path (
   input wire logic clock, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic pass_through_ctl, // high: transparent
   input wire logic capture_clock, // rising edge captures when latched
   input wire logic [xcvr_pkg::BYTE_WIDTH-1:0] source, // data source
   output logic [xcvr_pkg::BYTE_WIDTH-1:0] stored // held value
);

   logic capture_prev;

   // ------------------------------------------------------------
   // previous capture clock level for edge detection
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      capture_prev <= capture_clock;
   end

   // ------------------------------------------------------------
   // storage element
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         stored <= xcvr_pkg::BYTE_RESET;
      end else if (pass_through_ctl) begin
         stored <= source; // RQ8
      end else if (capture_clock && !capture_prev) begin
         stored <= source; // RQ10
      end
      // otherwise hold, incl. clock high when pass fell RQ9 RQ11
   end

endmodule

//--- backplane_transceiver_latch_path.sv
/*
 * backplane transceiver: eight-bit latched/clocked byte path and two
 * one-bit three-wire transceivers with feedback.
 * assumes all inputs synchronous to clock; the surrounding wiring
 * resolves pin levels from the oe fields.
 * data flops update whatever the enables, so turning a port around
 * never loses what the storage held.
 */
`timescale 1ns/10ps

// Contract
// [RQ1] backplane bit driven from card input while b_drive_enable high, else released
// [RQ2] feedback_out echoes backplane bit while y_output_enable_n low, else released
// [RQ3] both enables active: drive backplane and echo it on feedback_out
// [RQ4] card logic may tie both enables as one direction signal
// [RQ5] every path passes data without inversion
// [RQ6] wide_output_enable_n high releases all byte outputs on both sides
// [RQ7] wide enable low: flow_select high drives backplane, low drives card side
// [RQ8] pass_through_ctl high: card byte follows straight to backplane byte
// [RQ9] pass_through_ctl low, clock steady: hold stored value, ignore input
// [RQ10] pass_through_ctl low: capture card byte on rising a_to_b_clock
// [RQ11] clock high when pass_through_ctl fell: keep value from just before
// [RQ12] backplane-to-card path same modes using b_to_a_clock
// [RQ13] separate storage per direction, unaffected by the other
module backplane_transceiver_latch_path (
   input wire logic clock, // 10 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic wide_output_enable_n, // byte outputs enable, active low
   input wire logic flow_select, // high: card to backplane
   input wire logic pass_through_ctl, // high: transparent
   input wire logic a_to_b_clock, // card-to-backplane capture clock
   input wire logic b_to_a_clock, // backplane-to-card capture clock
   input wire logic [7:0] card_side_byte_in, // card byte pin level
   output xcvr_pkg::byte_pin_type card_side_byte, // card byte drive
   input wire logic [7:0] backplane_byte_in, // backplane byte pin level
   output xcvr_pkg::byte_pin_type backplane_byte, // backplane byte drive
   input wire logic [1:0] b_drive_enable, // per lane backplane drive enable
   input wire logic [1:0] y_output_enable_n, // per lane feedback enable, low
   input wire logic [1:0] card_bit, // per lane card input
   input wire logic [1:0] backplane_bit_in, // per lane backplane pin level
   output xcvr_pkg::lane_pin_type backplane_bit, // per lane backplane drive
   output xcvr_pkg::lane_pin_type feedback_out // per lane feedback drive
);

   // ------------------------------------------------------------
   // flops behind the output carriers
   // ------------------------------------------------------------
   logic [xcvr_pkg::BYTE_WIDTH-1:0] a_to_b_stored;
   logic [xcvr_pkg::BYTE_WIDTH-1:0] b_to_a_stored;
   logic backplane_byte_oe;
   logic card_side_byte_oe;
   logic [xcvr_pkg::BIT_LANES-1:0] lane_drive_oe;
   logic [xcvr_pkg::BIT_LANES-1:0] lane_drive_data;
   logic [xcvr_pkg::BIT_LANES-1:0] lane_feed_oe;
   logic [xcvr_pkg::BIT_LANES-1:0] lane_feed_data;

   // ------------------------------------------------------------
   // byte path storage, one per direction
   // ------------------------------------------------------------
   latch_path a_to_b_path ( // RQ13
      .clock(clock),
      .rst(rst),
      .pass_through_ctl(pass_through_ctl),
      .capture_clock(a_to_b_clock),
      .source(card_side_byte_in),
      .stored(a_to_b_stored)
   );

   latch_path b_to_a_path ( // RQ12
      .clock(clock),
      .rst(rst),
      .pass_through_ctl(pass_through_ctl),
      .capture_clock(b_to_a_clock),
      .source(backplane_byte_in),
      .stored(b_to_a_stored)
   );

   // ------------------------------------------------------------
   // byte output enables
   // ------------------------------------------------------------
   // oe flops only; byte data lives in the two latch paths
   always_ff @(posedge clock) begin
      if (rst) begin
         backplane_byte_oe <= xcvr_pkg::OE_RESET;
      end else begin
         backplane_byte_oe <= !wide_output_enable_n && flow_select; // RQ6 RQ7
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         card_side_byte_oe <= xcvr_pkg::OE_RESET;
      end else begin
         card_side_byte_oe <= !wide_output_enable_n && !flow_select; // RQ6 RQ7
      end
   end

   // ------------------------------------------------------------
   // one-bit three-wire lanes
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < xcvr_pkg::BIT_LANES; i++) begin : g_lane
         // one pass per lane; lanes share nothing
         always_ff @(posedge clock) begin
            if (rst) begin
               lane_drive_oe[i] <= xcvr_pkg::OE_RESET;
               lane_drive_data[i] <= xcvr_pkg::BIT_RESET;
            end else begin
               lane_drive_oe[i] <= b_drive_enable[i]; // RQ1 RQ3
               lane_drive_data[i] <= card_bit[i]; // RQ5
            end
         end

         // feedback samples the pin, so it echoes whoever drives the line
         always_ff @(posedge clock) begin
            if (rst) begin
               lane_feed_oe[i] <= xcvr_pkg::OE_RESET;
               lane_feed_data[i] <= xcvr_pkg::BIT_RESET;
            end else begin
               lane_feed_oe[i] <= !y_output_enable_n[i]; // RQ2 RQ3
               lane_feed_data[i] <= backplane_bit_in[i]; // RQ5
            end
         end

         a_lane_drive: assert property (@(posedge clock) disable iff (rst) // RQ1
            b_drive_enable[i] |=> backplane_bit.oe[i] && backplane_bit.data[i] == $past(card_bit[i]))
            else $error("lane does not drive backplane from card input");
         a_lane_release: assert property (@(posedge clock) disable iff (rst) // RQ1
            !b_drive_enable[i] |=> !backplane_bit.oe[i])
            else $error("lane drives backplane while disabled");
         a_lane_feedback: assert property (@(posedge clock) disable iff (rst) // RQ2
            !y_output_enable_n[i] |=> feedback_out.oe[i] && feedback_out.data[i] == $past(backplane_bit_in[i]))
            else $error("feedback does not echo backplane");
         a_lane_both: assert property (@(posedge clock) disable iff (rst) // RQ3
            b_drive_enable[i] && y_output_enable_n[i] == 1'h0 |=> backplane_bit.oe[i] && feedback_out.oe[i])
            else $error("lane does not drive and echo together");
         a_feed_release: assert property (@(posedge clock) disable iff (rst) // RQ2
            y_output_enable_n[i] |=> !feedback_out.oe[i])
            else $error("feedback driven while disabled");
         a_lane_isolate: assert property (@(posedge clock) disable iff (rst) // RQ2
            !b_drive_enable[i] && y_output_enable_n[i] |=> !backplane_bit.oe[i] && !feedback_out.oe[i])
            else $error("lane not isolated with both enables off");
         a_lane_true: assert property (@(posedge clock) disable iff (rst) // RQ5
            1'h1 |=> backplane_bit.data[i] == $past(card_bit[i]) && feedback_out.data[i] == $past(backplane_bit_in[i]))
            else $error("lane data inverted");
      end
   endgenerate

   // ------------------------------------------------------------
   // output carriers, every field straight from a flop
   // ------------------------------------------------------------
   assign backplane_byte = {backplane_byte_oe, a_to_b_stored};
   assign card_side_byte = {card_side_byte_oe, b_to_a_stored};
   assign backplane_bit = {lane_drive_oe, lane_drive_data};
   assign feedback_out = {lane_feed_oe, lane_feed_data};

   // ------------------------------------------------------------
   // byte path checks
   // ------------------------------------------------------------
   a_byte_isolate: assert property (@(posedge clock) disable iff (rst) // RQ6
      wide_output_enable_n |=> !backplane_byte.oe && !card_side_byte.oe)
      else $error("byte outputs driven while disabled");
   a_byte_flow: assert property (@(posedge clock) disable iff (rst) // RQ7
      !wide_output_enable_n |=> backplane_byte.oe == $past(flow_select) && card_side_byte.oe != $past(flow_select))
      else $error("byte direction wrong");
   a_byte_drive_bp: assert property (@(posedge clock) disable iff (rst) // RQ7
      !wide_output_enable_n && flow_select |=> backplane_byte.oe && !card_side_byte.oe)
      else $error("backplane byte not driven toward the bus");
   a_byte_drive_card: assert property (@(posedge clock) disable iff (rst) // RQ7
      !wide_output_enable_n && !flow_select |=> card_side_byte.oe && !backplane_byte.oe)
      else $error("card byte not driven toward the card");

   // ------------------------------------------------------------
   // card-to-backplane storage checks
   // ------------------------------------------------------------
   a_byte_transparent: assert property (@(posedge clock) disable iff (rst) // RQ8
      pass_through_ctl |=> backplane_byte.data == $past(card_side_byte_in) && card_side_byte.data == $past(backplane_byte_in))
      else $error("transparent path does not follow input");
   a_byte_hold: assert property (@(posedge clock) disable iff (rst) // RQ9
      !pass_through_ctl && $stable(a_to_b_clock) ##1 !pass_through_ctl && $stable(a_to_b_clock)
      |-> $stable(backplane_byte.data))
      else $error("latched value changed without capture edge");
   a_byte_capture: assert property (@(posedge clock) disable iff (rst) // RQ10
      !pass_through_ctl && $rose(a_to_b_clock) |=> backplane_byte.data == $past(card_side_byte_in))
      else $error("rising capture clock did not store card byte");
   a_byte_latched: assert property (@(posedge clock) disable iff (rst) // RQ9
      !pass_through_ctl && $stable(a_to_b_clock) |=> backplane_byte.data == $past(backplane_byte.data))
      else $error("latched byte followed its input");
   a_byte_fall_high: assert property (@(posedge clock) disable iff (rst) // RQ11
      $fell(pass_through_ctl) && a_to_b_clock && $past(a_to_b_clock)
      ##1 !pass_through_ctl && a_to_b_clock |-> backplane_byte.data == $past(backplane_byte.data, 1))
      else $error("value before latch close not kept");

   // ------------------------------------------------------------
   // backplane-to-card storage checks
   // ------------------------------------------------------------
   a_back_follow: assert property (@(posedge clock) disable iff (rst) // RQ12
      pass_through_ctl |=> card_side_byte.data == $past(backplane_byte_in))
      else $error("transparent card path does not follow backplane");
   a_back_capture: assert property (@(posedge clock) disable iff (rst) // RQ12
      !pass_through_ctl && $rose(b_to_a_clock) |=> card_side_byte.data == $past(backplane_byte_in))
      else $error("rising b_to_a_clock did not store backplane byte");
   a_back_isolated: assert property (@(posedge clock) disable iff (rst) // RQ13
      !pass_through_ctl && $stable(b_to_a_clock) ##1 !pass_through_ctl && $stable(b_to_a_clock)
      |-> $stable(card_side_byte.data))
      else $error("card-side storage disturbed by other direction");
   a_back_latched: assert property (@(posedge clock) disable iff (rst) // RQ12
      !pass_through_ctl && $stable(b_to_a_clock) |=> card_side_byte.data == $past(card_side_byte.data))
      else $error("latched card byte followed its input");
   a_back_fall_high: assert property (@(posedge clock) disable iff (rst) // RQ12
      $fell(pass_through_ctl) && b_to_a_clock && $past(b_to_a_clock)
      ##1 !pass_through_ctl && b_to_a_clock |-> card_side_byte.data == $past(card_side_byte.data, 1))
      else $error("card value before latch close not kept");

   // ------------------------------------------------------------
   // direction independence checks
   // ------------------------------------------------------------
   a_card_undisturbed: assert property (@(posedge clock) disable iff (rst) // RQ13
      !pass_through_ctl && $rose(a_to_b_clock) && $stable(b_to_a_clock) |=> $stable(card_side_byte.data))
      else $error("card storage moved on a backplane-direction capture");
   a_bus_undisturbed: assert property (@(posedge clock) disable iff (rst) // RQ13
      !pass_through_ctl && $rose(b_to_a_clock) && $stable(a_to_b_clock) |=> $stable(backplane_byte.data))
      else $error("backplane storage moved on a card-direction capture");

endmodule

//--- card_backplane_model.sv
/*
 card logic and backplane bus facing the transceiver; resolves pin levels.
 assumes the far side drives every line that the device releases.
*/
`timescale 1ns/10ps
module card_backplane_model (
   input wire logic [7:0] card_value, // card drive when released
   input wire logic [7:0] bp_value, // bus drive when released
   input wire logic [1:0] bit_value, // bus bit drive when released
   input wire logic dir_mode, // join lane enables
   input wire logic dir, // joint direction, high: card to bus
   input wire logic [1:0] en, // separate drive enables
   input wire logic [1:0] en_n, // separate feedback enables
   input wire xcvr_pkg::byte_pin_type card_side_byte, // device card drive
   input wire xcvr_pkg::byte_pin_type backplane_byte, // device bus drive
   input wire xcvr_pkg::lane_pin_type backplane_bit, // device bit drive
   output logic [7:0] card_level, // card pin level
   output logic [7:0] bp_level, // bus pin level
   output logic [1:0] bit_level, // bus bit level
   output logic [1:0] drive_en, // to drive enables
   output logic [1:0] feed_en_n // to feedback enables
);
   assign drive_en = dir_mode ? {2{dir}} : en;
   assign feed_en_n = dir_mode ? {2{dir}} : en_n;
   assign card_level = card_side_byte.oe ? card_side_byte.data : card_value;
   assign bp_level = backplane_byte.oe ? backplane_byte.data : bp_value;
   assign bit_level = (backplane_bit.oe & backplane_bit.data) | (~backplane_bit.oe & bit_value);
endmodule

//--- tb_backplane_transceiver_latch_path.sv
/*
 self-checking bench for the backplane transceiver.
 assumes outputs settle one clock after inputs are sampled.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_backplane_transceiver_latch_path;
   typedef struct {logic w, f; logic [7:0] a, b; logic boe, aoe; logic [7:0] d;} row_type;
   logic clock = 1'h0, rst = 1'h1, w_n = 1'h1, flow = 1'h0, pass = 1'h1, ck_ab = 1'h0, ck_ba = 1'h0;
   logic dir_mode = 1'h0, dir = 1'h0;
   logic [7:0] a_val = 8'h00, b_val = 8'h00, card_level, bp_level;
   logic [1:0] en = 2'h0, en_n = 2'h3, cbit = 2'h0, bit_level, drive_en, feed_en_n;
   xcvr_pkg::byte_pin_type card_side_byte, backplane_byte;
   xcvr_pkg::lane_pin_type backplane_bit, feedback_out;
   int n_errors = 0, cmp_count = 0;
   row_type rows [4] = '{'{1'h1, 1'h1, 8'h5a, 8'h00, 1'h0, 1'h0, 8'h00},
      '{1'h0, 1'h1, 8'ha5, 8'h00, 1'h1, 1'h0, 8'ha5}, '{1'h0, 1'h0, 8'h00, 8'h3c, 1'h0, 1'h1, 8'h3c},
      '{1'h1, 1'h0, 8'h00, 8'hc3, 1'h0, 1'h0, 8'h00}};
   backplane_transceiver_latch_path dut (.clock(clock), .rst(rst), .wide_output_enable_n(w_n),
      .flow_select(flow), .pass_through_ctl(pass), .a_to_b_clock(ck_ab), .b_to_a_clock(ck_ba),
      .card_side_byte_in(card_level), .card_side_byte(card_side_byte), .backplane_byte_in(bp_level),
      .backplane_byte(backplane_byte), .b_drive_enable(drive_en), .y_output_enable_n(feed_en_n),
      .card_bit(cbit), .backplane_bit_in(bit_level), .backplane_bit(backplane_bit), .feedback_out(feedback_out));
   card_backplane_model far (.card_value(a_val), .bp_value(b_val), .bit_value(2'h1), .dir_mode(dir_mode),
      .dir(dir), .en(en), .en_n(en_n), .card_side_byte(card_side_byte), .backplane_byte(backplane_byte),
      .backplane_bit(backplane_bit), .card_level(card_level), .bp_level(bp_level), .bit_level(bit_level),
      .drive_en(drive_en), .feed_en_n(feed_en_n));
   always #50 clock = ~clock;
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic conclude();
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      wait_n(11);
      `CHK({card_side_byte, backplane_byte, backplane_bit, feedback_out}, 26'h0)
      rst = 1'h0;
      foreach (rows[i]) begin
         {w_n, flow, a_val, b_val} = {rows[i].w, rows[i].f, rows[i].a, rows[i].b};
         wait_n(3);
         `CHK({backplane_byte.oe, card_side_byte.oe}, {rows[i].boe, rows[i].aoe})
         if (rows[i].boe) `CHK(backplane_byte.data, rows[i].d)
         if (rows[i].aoe) `CHK(card_side_byte.data, rows[i].d)
      end
      for (int k = 0; k < 4; k++) begin
         en = {2{k[0]}};
         en_n = {2{k[1]}};
         cbit = 2'h2;
         wait_n(3);
         `CHK(backplane_bit.oe, en)
         if (k[0]) `CHK(backplane_bit.data, 2'h2)
         `CHK(feedback_out.oe, ~en_n)
         if (!k[1]) `CHK(feedback_out.data, k[0] ? 2'h2 : 2'h1)
      end
      dir_mode = 1'h1;
      for (int k = 0; k < 2; k++) begin
         dir = k[0];
         wait_n(3);
         `CHK({backplane_bit.oe, feedback_out.oe}, k[0] ? 4'hc : 4'h3)
      end
      // held, clocked and late-latch cases
      {w_n, flow, a_val} = {1'h0, 1'h1, 8'h11};
      wait_n(3);
      {pass, a_val} = {1'h0, 8'h22};
      wait_n(3);
      `CHK(backplane_byte.data, 8'h11)
      ck_ab = 1'h1;
      wait_n(3);
      `CHK(backplane_byte.data, 8'h22)
      a_val = 8'h33;
      wait_n(3);
      `CHK(backplane_byte.data, 8'h22)
      {pass, a_val} = {1'h1, 8'h55};
      wait_n(3);
      {pass, a_val} = {1'h0, 8'h66};
      wait_n(3);
      `CHK(backplane_byte.data, 8'h55)
      {flow, b_val} = {1'h0, 8'h77};
      wait_n(3);
      `CHK(card_side_byte.data, 8'h55)
      ck_ba = 1'h1;
      wait_n(3);
      `CHK(card_side_byte.data, 8'h77)
      flow = 1'h1;
      wait_n(3);
      `CHK(backplane_byte.data, 8'h55)
      `CHK(card_side_byte.data, 8'h77)
      {flow, pass, b_val} = {1'h0, 1'h1, 8'h88};
      wait_n(3);
      {pass, b_val} = {1'h0, 8'h99};
      wait_n(3);
      `CHK(card_side_byte.data, 8'h88)
      conclude();
   end
   initial begin
      repeat (400) @(posedge clock);
      n_errors++;
      conclude();
   end
endmodule
